// ==== shared/psac_pkg.sv ====
package psac_pkg;
  // ==========================================
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_CTRL1 = 8'h40;
  localparam logic [7:0] IDX_CTRL2 = 8'h41;
  localparam logic [7:0] IDX_GAP = 8'h42;
  localparam logic [7:0] IDX_ARB1 = 8'h43;
  localparam logic [7:0] IDX_STATUS = 8'h46;
  // ==========================================
  // values after reset
  localparam logic [7:0] RST_CTRL1 = 8'h00;
  localparam logic [7:0] RST_CTRL2 = 8'h96;
  localparam logic [7:0] RST_ARB1 = 8'h80;
  // ==========================================
  // field positions
  localparam int CTRL1_WBUF_BIT = 3;
  localparam int CTRL1_LINE_BIT = 2;
  localparam int CTRL1_BURST_BIT = 1;
  localparam int CTRL1_RSVD_BIT = 0;
  // ==========================================
  // bus commands and timing
  localparam logic [3:0] CMD_READ_MULT = 4'hc;
  localparam logic [3:0] CMD_READ_LINE = 4'he;
  localparam logic [3:0] CMD_WRITE_INV = 4'hf;
  localparam logic [11:0] LINE_BYTES = 12'h010;
  localparam logic [11:0] DW_BYTES = 12'h004;
  localparam logic [6:0] MASK_CLK_16 = 7'h10;
  localparam logic [6:0] MASK_CLK_32 = 7'h20;
  localparam logic [6:0] MASK_CLK_64 = 7'h40;
  localparam logic [1:0] HOLD_EXTRA_CLK = 2'h2;
  // ==========================================
  // register layouts
  typedef struct packed {
    logic [3:0] upper;
    logic slave_write_buffer_on;
    logic line_read_on;
    logic local_burst_on;
    logic rsvd0;
  } psac_ctrl1_type;
  typedef struct packed {
    logic rsvd7;
    logic raw_clock_off;
    logic parity_raises_system_error;
    logic master_write_buffer_on;
    logic [1:0] disconnect_boundary_sel;
    logic line_disconnect_on;
    logic local_write_wait_on;
  } psac_ctrl2_type;
  typedef struct packed {
    logic grant_when_drained;
    logic rsvd6;
    logic retry_mask_on_line2;
    logic retry_mask_on_line1;
    logic retry_mask_on_line0;
    logic [1:0] retry_mask_period;
    logic hold_on_retry;
  } psac_arb_type;
endpackage

// ==== hw/psac_retry_mask.sv ====
module psac_retry_mask #(
  parameter int CW = 7
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // control
  input wire logic retry,
  input wire logic enable,
  input wire logic [1:0] period,
  // state
  output logic mask
);
  logic [CW-1:0] count;
  logic [CW-1:0] next_count;

  always_comb begin
    next_count = count;
    if (retry && enable) begin
      case (period)
        2'b01: next_count = CW'(psac_pkg::MASK_CLK_16);
        2'b10: next_count = CW'(psac_pkg::MASK_CLK_32);
        2'b11: next_count = CW'(psac_pkg::MASK_CLK_64);
        default: next_count = '0;
      endcase
    end else if (count != '0) begin
      next_count = count - CW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  assign mask = (count != '0);

  sequence s_load16;
    retry && enable && period == 2'b01;
  endsequence

  property p_mask16;
    @(posedge clk) disable iff (!rstn)
    s_load16 ##1 (!retry)[*8] ##1 (!retry)[*8] |-> mask ##1 !mask;
  endproperty
  a_mask16: assert property (p_mask16)
    else $error("retry mask not 16 clocks");

  property p_exempt;
    @(posedge clk) disable iff (!rstn)
    !enable && !mask |=> !mask;
  endproperty
  a_exempt: assert property (p_exempt)
    else $error("exempt line became masked");
endmodule

// ==== hw/psac_top.sv ====
// Functional notes
// - ctrl1 bit 3 turns slave write buffers on or off
// - line read bit or read multiple/line command gives full line read
// - local burst only for external write-and-invalidate; reads not affected
// - reserved bit 0 of ctrl1 reads zero
// - ctrl2 resets to 96h
// - ctrl2 bit 6 low enables the raw clock debug output
// - parity bit set: master raises SERR# on driven or seen PERR#
// - master buffers memory writes when enabled; I/O and locked never
// - slave disconnects bursts at 128/256/512/1024 byte boundary by field
// - line disconnect bit picks 16 byte boundary instead of field
// - wait bit inserts wait states on local write cycles
// - arbitration control 1 resets to 80h
// - grant policy bit: grant only when local buffers are empty
// - per line enable lets retry mask apply; 0 exempts the line
// - retried masked master ignored for none/16/32/64 clocks
// - hold on retry keeps local hold two extra clocks
module psac_top (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // avalon slave
  input wire logic [9:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // pci slave side
  input wire logic slave_data_valid,
  input wire logic [11:0] slave_addr,
  input wire logic slave_read_req,
  input wire logic [3:0] slave_cmd,
  input wire logic ext_master_write,
  output logic slave_disconnect,
  output logic line_read,
  output logic local_burst,
  output logic slave_write_buffer_on,
  output logic local_write_wait,
  // pci master side
  input wire logic master_mem_write,
  input wire logic master_locked,
  input wire logic perr_active,
  output logic master_write_buffer,
  output logic serr_active,
  // arbiter
  input wire logic [2:0] retry_line,
  input wire logic [2:0] req_line,
  input wire logic local_buffers_empty,
  output logic [2:0] req_eligible,
  output logic grant_allowed,
  output logic hold_extend,
  // debug
  output logic raw_clock_en
);
  // ==========================================
  // registers
  psac_pkg::psac_ctrl1_type ctrl1;
  psac_pkg::psac_ctrl2_type ctrl2;
  psac_pkg::psac_arb_type arb1;
  logic [2:0] mask;
  logic [2:0] mask_on;
  logic [1:0] hold_count;
  logic [7:0] index;
  logic aligned;
  logic wr_take;
  logic [7:0] next_rd;
  logic [11:0] bnd;
  logic [11:0] last_dw;

  assign index = address[9:2];
  assign aligned = (address[1:0] == 2'b00);
  assign wr_take = write && !waitrequest && aligned;
  assign mask_on = {arb1.retry_mask_on_line2, arb1.retry_mask_on_line1,
                    arb1.retry_mask_on_line0};

  // ==========================================
  // bus handshake
  // one wait cycle per access; re-asserts after the accepting edge
  always_ff @(posedge clk) begin
    if (!rstn) begin
      waitrequest <= 1'b1;
    end else if ((read || write) && waitrequest) begin
      waitrequest <= 1'b0;
    end else begin
      waitrequest <= 1'b1;
    end
  end

  always_comb begin
    next_rd = 8'h00;
    if (aligned) begin
      case (index)
        psac_pkg::IDX_CTRL1: begin
          next_rd = ctrl1;
          next_rd[psac_pkg::CTRL1_RSVD_BIT] = 1'b0;
        end
        psac_pkg::IDX_CTRL2: next_rd = ctrl2;
        psac_pkg::IDX_ARB1: next_rd = arb1;
        psac_pkg::IDX_STATUS: begin
          next_rd = {3'h0, slave_disconnect, hold_extend, mask};
        end
        default: next_rd = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      readdata <= 32'h0000_0000;
    end else if (read && waitrequest) begin
      readdata <= {24'h00_0000, next_rd};
    end
  end

  // ==========================================
  // register writes
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ctrl1 <= psac_pkg::RST_CTRL1;
    end else if (wr_take && index == psac_pkg::IDX_CTRL1) begin
      ctrl1 <= writedata[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      ctrl2 <= psac_pkg::RST_CTRL2;
    end else if (wr_take && index == psac_pkg::IDX_CTRL2) begin
      ctrl2 <= writedata[7:0];
    end
  end

  // bit 6 is stored as written; software is expected to keep it set
  always_ff @(posedge clk) begin
    if (!rstn) begin
      arb1 <= psac_pkg::RST_ARB1;
    end else if (wr_take && index == psac_pkg::IDX_ARB1) begin
      arb1 <= writedata[7:0];
    end
  end

  // ==========================================
  // slave path
  always_ff @(posedge clk) begin
    if (!rstn) begin
      slave_write_buffer_on <= 1'b0;
      local_write_wait <= 1'b0;
      raw_clock_en <= 1'b0;
    end else begin
      slave_write_buffer_on <= ctrl1.slave_write_buffer_on;
      local_write_wait <= ctrl2.local_write_wait_on;
      raw_clock_en <= !ctrl2.raw_clock_off;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      line_read <= 1'b0;
    end else begin
      line_read <= slave_read_req && (ctrl1.line_read_on ||
                   slave_cmd == psac_pkg::CMD_READ_MULT ||
                   slave_cmd == psac_pkg::CMD_READ_LINE);
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      local_burst <= 1'b0;
    end else begin
      local_burst <= ctrl1.local_burst_on && ext_master_write &&
                     slave_cmd == psac_pkg::CMD_WRITE_INV;
    end
  end

  always_comb begin
    case (ctrl2.disconnect_boundary_sel)
      2'b00: bnd = 12'h080;
      2'b01: bnd = 12'h100;
      2'b10: bnd = 12'h200;
      default: bnd = 12'h400;
    endcase
    if (ctrl2.line_disconnect_on) begin
      bnd = psac_pkg::LINE_BYTES;
    end
    last_dw = bnd - psac_pkg::DW_BYTES;
  end

  // disconnect flagged on the last dword before the boundary
  always_ff @(posedge clk) begin
    if (!rstn) begin
      slave_disconnect <= 1'b0;
    end else begin
      slave_disconnect <= slave_data_valid &&
                          ((slave_addr & (bnd - 12'h001)) == last_dw);
    end
  end

  // ==========================================
  // master path
  always_ff @(posedge clk) begin
    if (!rstn) begin
      master_write_buffer <= 1'b0;
      serr_active <= 1'b0;
    end else begin
      master_write_buffer <= ctrl2.master_write_buffer_on &&
                             master_mem_write && !master_locked;
      serr_active <= ctrl2.parity_raises_system_error && perr_active;
    end
  end

  // ==========================================
  // arbiter
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_line
      psac_retry_mask #(.CW(7)) u_mask (
        .clk(clk),
        .rstn(rstn),
        .retry(retry_line[g]),
        .enable(mask_on[g]),
        .period(arb1.retry_mask_period),
        .mask(mask[g])
      );
      always_ff @(posedge clk) begin
        if (!rstn) begin
          req_eligible[g] <= 1'b0;
        end else begin
          req_eligible[g] <= req_line[g] && !mask[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!rstn) begin
      grant_allowed <= 1'b0;
    end else begin
      grant_allowed <= !arb1.grant_when_drained || local_buffers_empty;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      hold_count <= 2'h0;
    end else if (arb1.hold_on_retry && retry_line != 3'b000) begin
      hold_count <= psac_pkg::HOLD_EXTRA_CLK;
    end else if (hold_count != 2'h0) begin
      hold_count <= hold_count - 2'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      hold_extend <= 1'b0;
    end else begin
      // retry cycle itself, then both extra clocks from the counter
      hold_extend <= (arb1.hold_on_retry && retry_line != 3'b000) ||
                     hold_count != 2'h0;
    end
  end

  // ==========================================
  // checks
  property p_ctrl2_reset;
    @(posedge clk) !rstn ##1 rstn |-> ctrl2 == psac_pkg::RST_CTRL2;
  endproperty
  a_ctrl2_reset: assert property (p_ctrl2_reset)
    else $error("ctrl2 reset value wrong");

  property p_arb1_reset;
    @(posedge clk) !rstn ##1 rstn |-> arb1 == psac_pkg::RST_ARB1;
  endproperty
  a_arb1_reset: assert property (p_arb1_reset)
    else $error("arb1 reset value wrong");

  property p_rsvd_zero;
    @(posedge clk) disable iff (!rstn)
    read && waitrequest && address == {psac_pkg::IDX_CTRL1, 2'b00}
    |=> readdata[0] == 1'b0;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero)
    else $error("reserved bit reads one");

  property p_wbuf_follow;
    @(posedge clk) disable iff (!rstn)
    wr_take && index == psac_pkg::IDX_CTRL1
    |=> ##1 slave_write_buffer_on ==
        $past(writedata[psac_pkg::CTRL1_WBUF_BIT], 2);
  endproperty
  a_wbuf_follow: assert property (p_wbuf_follow)
    else $error("slave write buffer enable not followed");

  property p_line_disc;
    @(posedge clk) disable iff (!rstn)
    ctrl2.line_disconnect_on && slave_data_valid &&
    slave_addr[3:0] == 4'hc |=> slave_disconnect;
  endproperty
  a_line_disc: assert property (p_line_disc)
    else $error("no disconnect at line boundary");

  property p_field_disc;
    @(posedge clk) disable iff (!rstn)
    !ctrl2.line_disconnect_on && ctrl2.disconnect_boundary_sel == 2'b00 &&
    slave_data_valid && slave_addr[6:0] == 7'h7c |=> slave_disconnect;
  endproperty
  a_field_disc: assert property (p_field_disc)
    else $error("no disconnect at 128 byte boundary");

  property p_burst_only_wi;
    @(posedge clk) disable iff (!rstn)
    slave_cmd != psac_pkg::CMD_WRITE_INV |=> !local_burst;
  endproperty
  a_burst_only_wi: assert property (p_burst_only_wi)
    else $error("local burst outside write and invalidate");

  property p_locked_unbuffered;
    @(posedge clk) disable iff (!rstn)
    master_locked |=> !master_write_buffer;
  endproperty
  a_locked_unbuffered: assert property (p_locked_unbuffered)
    else $error("locked cycle buffered");

  property p_serr;
    @(posedge clk) disable iff (!rstn)
    perr_active |=> serr_active == $past(ctrl2.parity_raises_system_error);
  endproperty
  a_serr: assert property (p_serr)
    else $error("serr does not follow parity setting");

  property p_grant;
    @(posedge clk) disable iff (!rstn)
    arb1.grant_when_drained && !local_buffers_empty |=> !grant_allowed;
  endproperty
  a_grant: assert property (p_grant)
    else $error("grant while buffers not empty");

  sequence s_hold_start;
    arb1.hold_on_retry && retry_line != 3'b000;
  endsequence

  property p_hold2;
    @(posedge clk) disable iff (!rstn)
    s_hold_start ##1 (retry_line == 3'b000)[*4]
    |-> !hold_extend && $past(hold_extend) && $past(hold_extend, 2) &&
        $past(hold_extend, 3);
  endproperty
  a_hold2: assert property (p_hold2)
    else $error("hold not extended two clocks");
endmodule

// ==== verification/psac_pci_agent.sv ====
// ==========================================
// far-side masters and targets: masters keep requesting, a target
// retries one line on command, either at once or four clocks late
module psac_pci_agent (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // commands from the bench
  input wire logic go,
  input wire logic [1:0] line,
  input wire logic slow,
  input wire logic [2:0] want,
  // request and retry lines
  output logic [2:0] req_line,
  output logic [2:0] retry_line
);
  timeunit 1ns;
  timeprecision 1ns;
  logic armed;
  logic [1:0] wait_cnt;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      req_line <= 3'h0;
      retry_line <= 3'h0;
      armed <= 1'b0;
      wait_cnt <= 2'h0;
    end else begin
      // a retried master returns at once, so its request never drops
      req_line <= want;
      if ((go && !slow) || (armed && wait_cnt == 2'h0)) begin
        retry_line <= 3'h1 << line;
      end else begin
        retry_line <= 3'h0;
      end
      if (go && slow) begin
        armed <= 1'b1;
        wait_cnt <= 2'h3;
      end else if (armed && wait_cnt == 2'h0) begin
        armed <= 1'b0;
      end else if (armed) begin
        wait_cnt <= wait_cnt - 2'h1;
      end
    end
  end
endmodule

// ==== verification/tb_psac_top.sv ====
module tb_psac_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] C1 = psac_pkg::IDX_CTRL1;
  localparam logic [7:0] C2 = psac_pkg::IDX_CTRL2;
  localparam logic [7:0] A1 = psac_pkg::IDX_ARB1;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [9:0] address = 10'h000;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic waitrequest;
  logic slave_data_valid = 1'b0;
  logic [11:0] slave_addr = 12'h000;
  logic slave_read_req = 1'b0;
  logic [3:0] slave_cmd = 4'h0;
  logic ext_master_write = 1'b0;
  logic master_mem_write = 1'b0;
  logic master_locked = 1'b0;
  logic perr_active = 1'b0;
  logic local_buffers_empty = 1'b0;
  logic go = 1'b0;
  logic slow = 1'b0;
  logic [1:0] line = 2'h0;
  logic [2:0] want = 3'h7;
  logic [2:0] req_line;
  logic [2:0] retry_line;
  logic [2:0] req_eligible;
  logic slave_disconnect, line_read, local_burst, slave_write_buffer_on;
  logic local_write_wait, master_write_buffer, serr_active;
  logic grant_allowed, hold_extend, raw_clock_en;
  logic [3:0] cmds [4];
  logic [31:0] exp_q [$];
  int bad_count = 0;
  int total_checks = 0;

  always #50 clk = ~clk;

  psac_top u_dut (.clk(clk), .rstn(rstn), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .slave_data_valid(slave_data_valid),
    .slave_addr(slave_addr), .slave_read_req(slave_read_req),
    .slave_cmd(slave_cmd), .ext_master_write(ext_master_write),
    .slave_disconnect(slave_disconnect), .line_read(line_read),
    .local_burst(local_burst), .local_write_wait(local_write_wait),
    .slave_write_buffer_on(slave_write_buffer_on),
    .master_mem_write(master_mem_write), .master_locked(master_locked),
    .perr_active(perr_active), .master_write_buffer(master_write_buffer),
    .serr_active(serr_active), .retry_line(retry_line),
    .req_line(req_line), .local_buffers_empty(local_buffers_empty),
    .req_eligible(req_eligible), .grant_allowed(grant_allowed),
    .hold_extend(hold_extend), .raw_clock_en(raw_clock_en));

  psac_pci_agent u_agent (.clk(clk), .rstn(rstn), .go(go), .line(line),
    .slow(slow), .want(want), .req_line(req_line),
    .retry_line(retry_line));

  // ==========================================
  // checking and verdict
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    if (bad_count == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // read data are taken only at the accepting edge
  always @(posedge clk) begin
    if (read && !waitrequest && exp_q.size() > 0) begin
      check(readdata, exp_q.pop_front());
    end
  end

  // ==========================================
  // register bus and helpers
  task automatic bus(input logic wr, input logic [7:0] idx,
                     input logic [7:0] d);
    int n;
    @(posedge clk);
    address <= {idx, 2'b00};
    writedata <= {24'h0, d};
    read <= !wr;
    write <= wr;
    if (!wr) exp_q.push_back({24'h0, d});
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (!waitrequest) break;
    end
    read <= 1'b0;
    write <= 1'b0;
    if (n == 20) begin
      bad_count++;
      test_done();
    end
  endtask

  task automatic settle();
    repeat (2) @(posedge clk);
  endtask

  // retry one line, count masked and hold clocks over a fixed window
  task automatic rmask(input logic [7:0] arb, input logic [1:0] ln,
                       input logic twice, input int en, input int eh);
    int i, n, h;
    n = 0;
    h = 0;
    bus(1'b1, A1, arb);
    line <= ln;
    slow <= 1'($urandom);
    for (i = 0; i < 110; i++) begin
      go <= (i == 0) || (twice && i == 8);
      @(posedge clk);
      n += !req_eligible[ln];
      h += hold_extend;
    end
    go <= 1'b0;
    check(n, en);
    check(h, eh);
  endtask

  // ==========================================
  // main sequence
  initial begin
    int i, n;
    logic [7:0] r;
    r = 8'($urandom(32'h15b64729));
    cmds = '{psac_pkg::CMD_READ_MULT, psac_pkg::CMD_READ_LINE, 4'h6,
             psac_pkg::CMD_WRITE_INV};
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    bus(1'b0, C1, 8'h00);
    bus(1'b0, C2, 8'h96);
    bus(1'b0, psac_pkg::IDX_GAP, 8'h00);
    bus(1'b0, A1, 8'h80);
    bus(1'b0, psac_pkg::IDX_STATUS, 8'h00);
    bus(1'b0, 8'h50, 8'h00);
    check(raw_clock_en, 1'b1);
    bus(1'b1, psac_pkg::IDX_GAP, 8'hff);
    bus(1'b0, psac_pkg::IDX_GAP, 8'h00);
    for (i = 0; i < 4; i++) begin
      r = 8'($urandom);
      bus(1'b1, C1, r);
      bus(1'b0, C1, r & 8'hfe);
      settle();
      check(slave_write_buffer_on, r[3]);
    end
    ext_master_write <= 1'b1;
    slave_read_req <= 1'b1;
    for (i = 0; i < 8; i++) begin
      bus(1'b1, C1, {5'h0, i[2], i[2], 1'b0});
      slave_cmd <= cmds[i[1:0]];
      settle();
      check(line_read, i[2] || i[1:0] < 2);
      check(local_burst, i[2] && i[1:0] == 3);
    end
    ext_master_write <= 1'b0;
    slave_read_req <= 1'b0;
    for (i = 0; i < 6; i++) begin
      r = 8'($urandom) & 8'h7f;
      bus(1'b1, C2, r);
      bus(1'b0, C2, r);
      {perr_active, master_mem_write, master_locked} <= 3'($urandom);
      settle();
      check(serr_active, r[5] && perr_active);
      check(master_write_buffer, r[4] && master_mem_write
            && !master_locked);
      check(local_write_wait, r[0]);
      check(raw_clock_en, !r[6]);
    end
    slave_data_valid <= 1'b1;
    for (i = 0; i < 8; i++) begin
      bus(1'b1, C2, {4'h0, i[1:0], i[2], 1'b0});
      n = i[2] ? 16 : 128 << i[1:0];
      slave_addr <= 12'(n - 4);
      settle();
      check(slave_disconnect, 1'b1);
      slave_addr <= 12'(n - 8);
      settle();
      check(slave_disconnect, 1'b0);
    end
    slave_data_valid <= 1'b0;
    for (i = 0; i < 4; i++) begin
      bus(1'b1, A1, {i[1], 7'h40});
      local_buffers_empty <= i[0];
      settle();
      check(grant_allowed, !i[1] || i[0]);
    end
    rmask(8'hcb, 2'h0, 1'b0, 16, 3);
    rmask(8'hcc, 2'h0, 1'b0, 32, 0);
    rmask(8'hce, 2'h0, 1'b0, 64, 0);
    rmask(8'hc9, 2'h0, 1'b0, 0, 3);
    rmask(8'hcb, 2'h1, 1'b0, 0, 3);
    rmask(8'he3, 2'h2, 1'b0, 16, 3);
    rmask(8'hcb, 2'h0, 1'b1, 24, 6);
    for (i = 0; i < 4; i++) begin
      want <= 3'($urandom);
      repeat (3) @(posedge clk);
      check(req_eligible, want);
    end
    test_done();
  end
endmodule
